/* File: verilog/osc_regs_pkg.sv */
// Register map, field positions and timing of the oscillator register bank
package osc_regs_pkg;
    localparam logic [7:0] OFS_NV_CONTROL      = 8'h31;
    localparam logic [7:0] OFS_MEM_START_PTR   = 8'h33;
    localparam logic [7:0] OFS_SRAM_DATA_WIN   = 8'h35;
    localparam logic [7:0] OFS_PROG_UNLOCK_KEY = 8'h38;
    localparam logic [7:0] OFS_LIVE_FLAGS      = 8'h42;
    localparam logic [7:0] OFS_SOFT_RESET      = 8'h48;
    localparam logic [7:0] OFS_FRAC_NUM_HI     = 8'h20;
    localparam logic [7:0] OFS_FRAC_NUM_MID    = 8'h21;
    localparam logic [7:0] OFS_FRAC_NUM_LO     = 8'h22;

    localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hBE;
    localparam logic [7:0] RESET_BYTE       = 8'h00;

    localparam int NV_PROG_GO_BIT    = 0;
    localparam int NV_ERASE_GO_BIT   = 1;
    localparam int NV_BUSY_BIT       = 2;
    localparam int LIVE_CAL_BIT      = 0;
    localparam int LIVE_LOL_BIT      = 1;
    localparam int PLL_SOFT_RST_BIT  = 1;

    localparam int SRAM_ADDR_W = 5;
    localparam int SRAM_DEPTH  = 32;
    localparam int MEM_PTR_W   = 7;
    localparam int FRAC_W      = 22;
    localparam int BUSY_CNT_W  = 24;

    localparam int CLK_HZ       = 100_000_000;
    localparam int PROG_TIME_MS = 115;
    localparam int PROG_CYCLES  = PROG_TIME_MS * (CLK_HZ / 1000);

    // Arbitrary neutral bus address
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h58;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_WBYTE    = 7'h08,
        ST_WACK     = 7'h10,
        ST_RBYTE    = 7'h20,
        ST_RACK     = 7'h40
    } serial_state_t;
endpackage

/* File: verilog/serial_byte_slave.sv */
// Two-wire serial target: bit timing, address match, byte strobes
module serial_byte_slave (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    input  wire logic [6:0] dev_addr,
    input  wire logic [7:0] rd_data,
    output logic            sda_oe_n,
    output logic            txn_end,
    output logic            wr_valid,
    output logic            wr_first,
    output logic [7:0]      wr_data,
    output logic            rd_req
);
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_lv_q;
    logic       sda_lv_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    osc_regs_pkg::serial_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic       read_q;
    logic       first_q;
    logic       acked_q;
    logic       in_txn_q;

    // Pin synchronisers, change accepted once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s    <= 3'h7;
            sda_s    <= 3'h7;
            scl_lv_q <= 1'b1;
            sda_lv_q <= 1'b1;
        end else begin
            scl_s <= {scl_s[1:0], scl_pin};
            sda_s <= {sda_s[1:0], sda_pin};
            if (scl_s[1] == scl_s[2]) begin
                scl_lv_q <= scl_s[2];
            end
            if (sda_s[1] == sda_s[2]) begin
                sda_lv_q <= sda_s[2];
            end
        end
    end

    assign scl_rise   = scl_s[1] & scl_s[2] & ~scl_lv_q;
    assign scl_fall   = ~scl_s[1] & ~scl_s[2] & scl_lv_q;
    assign start_seen = ~sda_s[1] & ~sda_s[2] & sda_lv_q & scl_lv_q & ~scl_fall;
    assign stop_seen  = sda_s[1] & sda_s[2] & ~sda_lv_q & scl_lv_q & ~scl_fall;
    assign wr_data    = shift_q;

    // Frame state machine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= osc_regs_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            read_q    <= 1'b0;
            first_q   <= 1'b0;
            acked_q   <= 1'b0;
            in_txn_q  <= 1'b0;
            sda_oe_n  <= 1'b1;
            txn_end   <= 1'b0;
            wr_valid  <= 1'b0;
            wr_first  <= 1'b0;
            rd_req    <= 1'b0;
        end else begin
            txn_end  <= 1'b0;
            wr_valid <= 1'b0;
            rd_req   <= 1'b0;
            if (start_seen) begin
                state_q   <= osc_regs_pkg::ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_n  <= 1'b1;
                in_txn_q  <= 1'b1;
            end else if (stop_seen) begin
                state_q  <= osc_regs_pkg::ST_IDLE;
                sda_oe_n <= 1'b1;
                txn_end  <= in_txn_q;
                in_txn_q <= 1'b0;
            end else begin
                unique case (state_q)
                    osc_regs_pkg::ST_IDLE: begin
                        sda_oe_n <= 1'b1;
                    end
                    osc_regs_pkg::ST_ADDR, osc_regs_pkg::ST_WBYTE: begin
                        if (scl_rise) begin
                            shift_q   <= {shift_q[6:0], sda_lv_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            if (state_q == osc_regs_pkg::ST_WBYTE) begin
                                sda_oe_n <= 1'b0;
                                wr_valid <= 1'b1;
                                wr_first <= first_q;
                                first_q  <= 1'b0;
                                state_q  <= osc_regs_pkg::ST_WACK;
                            end else if (shift_q[7:1] == dev_addr) begin
                                sda_oe_n <= 1'b0;
                                read_q   <= shift_q[0];
                                first_q  <= ~shift_q[0];
                                state_q  <= osc_regs_pkg::ST_ADDR_ACK;
                            end else begin
                                state_q <= osc_regs_pkg::ST_IDLE;
                            end
                        end
                    end
                    osc_regs_pkg::ST_ADDR_ACK: begin
                        if (scl_rise && read_q) begin
                            rd_req <= 1'b1;
                        end else if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (read_q) begin
                                shift_q  <= rd_data;
                                sda_oe_n <= rd_data[7];
                                state_q  <= osc_regs_pkg::ST_RBYTE;
                            end else begin
                                sda_oe_n <= 1'b1;
                                state_q  <= osc_regs_pkg::ST_WBYTE;
                            end
                        end
                    end
                    osc_regs_pkg::ST_WACK: begin
                        if (scl_fall) begin
                            sda_oe_n  <= 1'b1;
                            bit_cnt_q <= 4'h0;
                            state_q   <= osc_regs_pkg::ST_WBYTE;
                        end
                    end
                    osc_regs_pkg::ST_RBYTE: begin
                        if (scl_rise) begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_q == 4'h8) begin
                                sda_oe_n <= 1'b1;
                                state_q  <= osc_regs_pkg::ST_RACK;
                            end else begin
                                shift_q  <= {shift_q[6:0], 1'b0};
                                sda_oe_n <= shift_q[6];
                            end
                        end
                    end
                    osc_regs_pkg::ST_RACK: begin
                        if (scl_rise) begin
                            acked_q <= ~sda_lv_q;
                            rd_req  <= ~sda_lv_q;
                        end else if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (acked_q) begin
                                shift_q  <= rd_data;
                                sda_oe_n <= rd_data[7];
                                state_q  <= osc_regs_pkg::ST_RBYTE;
                            end else begin
                                state_q <= osc_regs_pkg::ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_q <= osc_regs_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

/* File: verilog/osc_register_bank.sv */
// Oscillator register bank: SRAM window, program unlock, live flags, soft reset
// How it works
// - First read of the SRAM window returns the byte at the start pointer.
// - First write to the SRAM window stores the byte at the start pointer.
// - Later window accesses in the same transaction step the SRAM address by one.
// - After the first window access the register address stays on the window.
// - Window mode ends with the transaction; the next one restarts at the pointer.
// - Programming starts only if the previous transaction wrote the unlock key.
// - Only the key byte 0xBE unlocks programming.
// - Live flags show present loss of lock (bit 1) and calibration (bit 0).
// - Soft reset bits clear themselves after a write.
// - Soft reset register always reads 0x00.
// - Writing 1 to soft reset bit 1 resets PLL calibrator and dividers.
// - Numerator update takes effect whole, so the output never sees a mixed value.
// - Only the low five pointer bits address the SRAM.
// - Program and erase go bits clear themselves.
// - A program cycle stays busy for about 115 ms.
module osc_register_bank #(
    parameter int         PROG_CYCLES = osc_regs_pkg::PROG_CYCLES,
    parameter logic [6:0] DEV_ADDR    = osc_regs_pkg::DEV_ADDR_DEFAULT
) (
    input  wire logic                             REF_CLK,
    input  wire logic                             RSTN,
    input  wire logic                             SCL,
    input  wire logic                             SDA_IN,
    output logic                                  SDA_OE_N,
    input  wire logic                             PLL_LOCK_LOST,
    input  wire logic                             PLL_CAL_ACTIVE,
    output logic                                  PLL_SOFT_RESET,
    output logic                                  NV_BUSY,
    output logic                                  NV_ERASE_SEL,
    output logic [osc_regs_pkg::FRAC_W-1:0]       FRAC_NUM
);
    logic       txn_end;
    logic       wr_valid;
    logic       wr_first;
    logic [7:0] wr_data;
    logic       rd_req;
    logic [7:0] rd_data_q;
    logic [7:0] rd_mux;
    logic [7:0] reg_ptr_q;
    logic       ram_mode_q;
    logic [osc_regs_pkg::SRAM_ADDR_W-1:0] sram_addr_q;
    logic [osc_regs_pkg::SRAM_ADDR_W-1:0] sram_addr_d;
    logic [7:0] sram_q [osc_regs_pkg::SRAM_DEPTH];
    logic [osc_regs_pkg::MEM_PTR_W-1:0] mem_ptr_q;
    logic [7:0] unlock_key_q;
    logic       armed_q;
    logic       txn_unlock_q;
    logic       txn_other_q;
    logic       busy_q;
    logic [osc_regs_pkg::BUSY_CNT_W-1:0] busy_cnt_q;
    logic [5:0] frac_hi_q;
    logic [7:0] frac_mid_q;
    logic [1:0] live_s1;
    logic [1:0] live_s2;
    logic [1:0] live_s3;
    logic [1:0] live_q;
    logic       data_wr;
    logic       access;
    logic       hit_ram;
    logic       start_prog;

    serial_byte_slave u_serial (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .scl_pin  (SCL),
        .sda_pin  (SDA_IN),
        .dev_addr (DEV_ADDR),
        .rd_data  (rd_data_q),
        .sda_oe_n (SDA_OE_N),
        .txn_end  (txn_end),
        .wr_valid (wr_valid),
        .wr_first (wr_first),
        .wr_data  (wr_data),
        .rd_req   (rd_req)
    );

    assign data_wr     = wr_valid & ~wr_first;
    assign access      = data_wr | rd_req;
    assign hit_ram     = (reg_ptr_q == osc_regs_pkg::OFS_SRAM_DATA_WIN);
    assign sram_addr_d = ram_mode_q ? sram_addr_q + 5'h01 : mem_ptr_q[osc_regs_pkg::SRAM_ADDR_W-1:0];
    assign start_prog  = data_wr && reg_ptr_q == osc_regs_pkg::OFS_NV_CONTROL && armed_q && !busy_q
                         && (wr_data[osc_regs_pkg::NV_PROG_GO_BIT] || wr_data[osc_regs_pkg::NV_ERASE_GO_BIT]);

    // Register pointer and window mode
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            reg_ptr_q   <= osc_regs_pkg::RESET_BYTE;
            ram_mode_q  <= 1'b0;
            sram_addr_q <= 5'h00;
        end else begin
            if (wr_valid && wr_first) begin
                reg_ptr_q <= wr_data;
            end else if (access && !hit_ram) begin
                reg_ptr_q <= reg_ptr_q + 8'h01;
            end
            if (txn_end) begin
                ram_mode_q <= 1'b0;
            end else if (access && hit_ram) begin
                ram_mode_q  <= 1'b1;
                sram_addr_q <= sram_addr_d;
            end
        end
    end

    // SRAM array
    always_ff @(posedge REF_CLK) begin
        if (data_wr && hit_ram) begin
            sram_q[sram_addr_d] <= wr_data;
        end
    end

    // Read data mux
    always_comb begin
        unique case (reg_ptr_q)
            osc_regs_pkg::OFS_SRAM_DATA_WIN:   rd_mux = sram_q[sram_addr_d];
            osc_regs_pkg::OFS_MEM_START_PTR:   rd_mux = {1'b0, mem_ptr_q};
            osc_regs_pkg::OFS_PROG_UNLOCK_KEY: rd_mux = unlock_key_q;
            osc_regs_pkg::OFS_LIVE_FLAGS:      rd_mux = {6'h00, live_q};
            osc_regs_pkg::OFS_SOFT_RESET:      rd_mux = osc_regs_pkg::RESET_BYTE;
            osc_regs_pkg::OFS_NV_CONTROL:      rd_mux = {5'h00, busy_q, 2'h0};
            osc_regs_pkg::OFS_FRAC_NUM_HI:     rd_mux = {2'h0, FRAC_NUM[21:16]};
            osc_regs_pkg::OFS_FRAC_NUM_MID:    rd_mux = FRAC_NUM[15:8];
            osc_regs_pkg::OFS_FRAC_NUM_LO:     rd_mux = FRAC_NUM[7:0];
            default:                           rd_mux = osc_regs_pkg::RESET_BYTE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_data_q <= osc_regs_pkg::RESET_BYTE;
        end else if (rd_req) begin
            rd_data_q <= rd_mux;
        end
    end

    // Writable registers and staged numerator
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            mem_ptr_q    <= 7'h00;
            unlock_key_q <= osc_regs_pkg::RESET_BYTE;
            frac_hi_q    <= 6'h00;
            frac_mid_q   <= 8'h00;
            FRAC_NUM     <= 22'h000000;
        end else if (data_wr) begin
            unique case (reg_ptr_q)
                osc_regs_pkg::OFS_MEM_START_PTR:   mem_ptr_q    <= wr_data[6:0];
                osc_regs_pkg::OFS_PROG_UNLOCK_KEY: unlock_key_q <= wr_data;
                osc_regs_pkg::OFS_FRAC_NUM_HI:     frac_hi_q    <= wr_data[5:0];
                osc_regs_pkg::OFS_FRAC_NUM_MID:    frac_mid_q   <= wr_data;
                osc_regs_pkg::OFS_FRAC_NUM_LO:     FRAC_NUM     <= {frac_hi_q, frac_mid_q, wr_data};
                default:                           mem_ptr_q    <= mem_ptr_q;
            endcase
        end
    end

    // Unlock tracking per transaction
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            armed_q      <= 1'b0;
            txn_unlock_q <= 1'b0;
            txn_other_q  <= 1'b0;
        end else if (txn_end) begin
            armed_q      <= txn_unlock_q & ~txn_other_q;
            txn_unlock_q <= 1'b0;
            txn_other_q  <= 1'b0;
        end else begin
            if (start_prog) begin
                armed_q <= 1'b0;
            end
            if (data_wr && reg_ptr_q == osc_regs_pkg::OFS_PROG_UNLOCK_KEY
                && wr_data == osc_regs_pkg::UNLOCK_KEY_VALUE) begin
                txn_unlock_q <= 1'b1;
            end else if (access) begin
                txn_other_q <= 1'b1;
            end
        end
    end

    // Program cycle timer
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            busy_q       <= 1'b0;
            busy_cnt_q   <= 24'h000000;
            NV_ERASE_SEL <= 1'b0;
        end else if (start_prog) begin
            busy_q       <= 1'b1;
            busy_cnt_q   <= osc_regs_pkg::BUSY_CNT_W'(PROG_CYCLES - 1);
            NV_ERASE_SEL <= wr_data[osc_regs_pkg::NV_ERASE_GO_BIT];
        end else if (busy_q) begin
            if (busy_cnt_q == 24'h000000) begin
                busy_q <= 1'b0;
            end else begin
                busy_cnt_q <= busy_cnt_q - 24'h000001;
            end
        end
    end

    assign NV_BUSY = busy_q;

    // Soft reset pulse
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            PLL_SOFT_RESET <= 1'b0;
        end else begin
            PLL_SOFT_RESET <= data_wr && reg_ptr_q == osc_regs_pkg::OFS_SOFT_RESET
                              && wr_data[osc_regs_pkg::PLL_SOFT_RST_BIT];
        end
    end

    // Live flag synchronisers
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            live_s1 <= 2'h0;
            live_s2 <= 2'h0;
            live_s3 <= 2'h0;
            live_q  <= 2'h0;
        end else begin
            live_s1 <= {PLL_LOCK_LOST, PLL_CAL_ACTIVE};
            live_s2 <= live_s1;
            live_s3 <= live_s2;
            live_q  <= (live_s2 & live_s3) | (live_q & (live_s2 ^ live_s3));
        end
    end

    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_ram_access;
        access && hit_ram;
    endsequence
    sequence s_prog_start;
        $rose(busy_q) ##1 busy_q[*8];
    endsequence

    property p_sram_first;
        s_ram_access and !ram_mode_q |=> sram_addr_q == $past(mem_ptr_q[4:0]) && ram_mode_q;
    endproperty
    a_sram_first: assert property (p_sram_first) else $error("first window access not at pointer");
    property p_sram_store;
        data_wr && hit_ram |=> sram_q[sram_addr_q] == $past(wr_data);
    endproperty
    a_sram_store: assert property (p_sram_store) else $error("window write not stored");
    property p_sram_step;
        s_ram_access and ram_mode_q |=> sram_addr_q == 5'($past(sram_addr_q) + 5'h01);
    endproperty
    a_sram_step: assert property (p_sram_step) else $error("window address did not step");
    property p_ptr_locked;
        s_ram_access and !(wr_valid && wr_first) |=> hit_ram;
    endproperty
    a_ptr_locked: assert property (p_ptr_locked) else $error("register address left window");
    property p_mode_end;
        txn_end |=> !ram_mode_q;
    endproperty
    a_mode_end: assert property (p_mode_end) else $error("window mode outlived transaction");
    property p_unlock_needed;
        $rose(busy_q) |-> $past(armed_q) && $past(reg_ptr_q) == osc_regs_pkg::OFS_NV_CONTROL;
    endproperty
    a_unlock_needed: assert property (p_unlock_needed) else $error("program without unlock");
    property p_go_read;
        rd_req && reg_ptr_q == osc_regs_pkg::OFS_NV_CONTROL |=> rd_data_q[1:0] == 2'h0;
    endproperty
    a_go_read: assert property (p_go_read) else $error("go bits read nonzero");
    property p_arm_key;
        txn_end && txn_unlock_q && !txn_other_q |=> armed_q && unlock_key_q == osc_regs_pkg::UNLOCK_KEY_VALUE;
    endproperty
    a_arm_key: assert property (p_arm_key) else $error("unlock armed with wrong key");
    property p_live_read;
        rd_req && reg_ptr_q == osc_regs_pkg::OFS_LIVE_FLAGS |=> rd_data_q == {6'h00, $past(live_q)};
    endproperty
    a_live_read: assert property (p_live_read) else $error("live flags read wrong");
    property p_sw_clear;
        PLL_SOFT_RESET |=> !PLL_SOFT_RESET;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("soft reset stuck");
    property p_sw_read;
        rd_req && reg_ptr_q == osc_regs_pkg::OFS_SOFT_RESET |=> rd_data_q == 8'h00;
    endproperty
    a_sw_read: assert property (p_sw_read) else $error("soft reset read nonzero");
    property p_sw_fire;
        data_wr && reg_ptr_q == osc_regs_pkg::OFS_SOFT_RESET && wr_data[1] |=> PLL_SOFT_RESET;
    endproperty
    a_sw_fire: assert property (p_sw_fire) else $error("soft reset not issued");
    property p_frac_whole;
        $changed(FRAC_NUM) |-> $past(data_wr) && $past(reg_ptr_q) == osc_regs_pkg::OFS_FRAC_NUM_LO;
    endproperty
    a_frac_whole: assert property (p_frac_whole) else $error("numerator changed piecewise");
    property p_busy_run;
        start_prog |=> s_prog_start;
    endproperty
    a_busy_run: assert property (p_busy_run) else $error("program cycle too short");
    property p_cancel;
        txn_end && txn_other_q |=> !armed_q;
    endproperty
    a_cancel: assert property (p_cancel) else $error("unlock survived other transaction");
endmodule

/* File: test/serial_host_model.sv */
// Host-side two-wire controller model driving the serial bus
module serial_host_model (
    input  wire logic clk,
    input  wire logic sda_oe_n,
    output logic      scl,
    output logic      sda_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sda_h = 1'b1;
    initial scl = 1'b1;
    // Open-drain wire with pull-up
    assign sda_in = sda_h & sda_oe_n;
    task automatic hc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // One bit: data changes while the clock is low, sampled at end of high phase
    task automatic xbit(input logic b, output logic r);
        scl = 1'b0;
        hc(2);
        sda_h = b;
        hc(6);
        scl = 1'b1;
        hc(8);
        r = sda_in;
    endtask
    // Start is cond(1, 0), stop is cond(0, 1)
    task automatic cond(input logic a, input logic b);
        logic r;
        xbit(a, r);
        sda_h = b;
        hc(8);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(ack_in, ack);
    endtask
endmodule

/* File: test/osc_register_bank_tb.sv */
// Self-checking bench for the oscillator register bank
module osc_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] bq_t [$];
    localparam int         PC = 20;
    localparam logic [6:0] DA = osc_regs_pkg::DEV_ADDR_DEFAULT;
    logic ref_clk, rstn, scl, sda_in, sda_oe_n, pll_lock_lost, cal, pll_rst, busy, erase_sel;
    logic [osc_regs_pkg::FRAC_W-1:0] frac;
    logic [31:0] rnd = 32'hB655;
    int err_count, samples_checked, cyc, pulses, busy_cyc, p;
    int sram [32];
    bq_t q;
    osc_register_bank #(.PROG_CYCLES(PC), .DEV_ADDR(DA)) i_osc_register_bank (
        .REF_CLK(ref_clk), .RSTN(rstn), .SCL(scl), .SDA_IN(sda_in), .SDA_OE_N(sda_oe_n),
        .PLL_LOCK_LOST(pll_lock_lost), .PLL_CAL_ACTIVE(cal), .PLL_SOFT_RESET(pll_rst), .NV_BUSY(busy),
        .NV_ERASE_SEL(erase_sel), .FRAC_NUM(frac));
    serial_host_model i_serial_host_model (.clk(ref_clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_in(sda_in));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        cyc++;
        pulses += (pll_rst === 1'b1);
        busy_cyc += (busy === 1'b1);
        if (cyc == 30000) begin
            err_count++;
            complete_run();
        end
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] r, input bq_t d);
        logic [7:0] x;
        logic a;
        i_serial_host_model.cond(1'b1, 1'b0);
        i_serial_host_model.xbyte({DA, 1'b0}, 1'b1, x, a);
        chk("address ack", 0, a);
        i_serial_host_model.xbyte(r, 1'b1, x, a);
        foreach (d[i]) i_serial_host_model.xbyte(d[i], 1'b1, x, a);
        i_serial_host_model.cond(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [7:0] r, input int n, output bq_t d);
        logic [7:0] x;
        logic a;
        d = {};
        i_serial_host_model.cond(1'b1, 1'b0);
        i_serial_host_model.xbyte({DA, 1'b0}, 1'b1, x, a);
        i_serial_host_model.xbyte(r, 1'b1, x, a);
        i_serial_host_model.cond(1'b1, 1'b0);
        i_serial_host_model.xbyte({DA, 1'b1}, 1'b1, x, a);
        for (int i = 0; i < n; i++) begin
            i_serial_host_model.xbyte(8'hFF, i == n - 1, x, a);
            d.push_back(x);
        end
        i_serial_host_model.cond(1'b0, 1'b1);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        pll_lock_lost = 1'b0;
        cal = 1'b0;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("reset outputs", 32'h1, {frac, erase_sel, busy, pll_rst, sda_oe_n});
        $display("reset test done");
        rnd = nxt(rnd);
        p = {rnd[6:5], 5'h1E};
        wr(osc_regs_pkg::OFS_MEM_START_PTR, {p[7:0]});
        q = {rnd[15:8], rnd[23:16], rnd[31:24]};
        for (int i = 0; i < 3; i++) sram[(p + i) % 32] = q[i];
        wr(osc_regs_pkg::OFS_SRAM_DATA_WIN, q);
        rd(osc_regs_pkg::OFS_SRAM_DATA_WIN, 3, q);
        for (int i = 0; i < 3; i++) chk("window byte", sram[(p + i) % 32], q[i]);
        rd(osc_regs_pkg::OFS_MEM_START_PTR, 1, q);
        chk("start pointer", p, q[0]);
        $display("window test done");
        for (int v = 0; v < 2; v++) begin
            p = pulses;
            wr(osc_regs_pkg::OFS_SOFT_RESET, {v == 0 ? 8'hFF : 8'h01});
            chk("soft reset pulses", p + (v == 0), pulses);
            rd(osc_regs_pkg::OFS_SOFT_RESET, 1, q);
            chk("soft reset read", 0, q[0]);
        end
        $display("soft reset test done");
        for (int i = 0; i < 4; i++) begin
            {pll_lock_lost, cal} = i[1:0];
            rd(osc_regs_pkg::OFS_LIVE_FLAGS, 1, q);
            chk("live flags", i, q[0]);
        end
        $display("live flag test done");
        rnd = nxt(rnd);
        wr(osc_regs_pkg::OFS_FRAC_NUM_HI, {rnd[7:0], rnd[15:8], rnd[23:16]});
        chk("numerator", {rnd[5:0], rnd[15:8], rnd[23:16]}, frac);
        rd(osc_regs_pkg::OFS_FRAC_NUM_HI, 3, q);
        chk("numerator read", {rnd[5:0], rnd[15:8], rnd[23:16]}, {q[0], q[1], q[2]});
        $display("numerator test done");
        for (int k = 0; k < 4; k++) begin
            wr(osc_regs_pkg::OFS_PROG_UNLOCK_KEY, {k == 1 ? 8'hBF : osc_regs_pkg::UNLOCK_KEY_VALUE});
            if (k == 2) rd(osc_regs_pkg::OFS_LIVE_FLAGS, 1, q);
            p = busy_cyc;
            wr(osc_regs_pkg::OFS_NV_CONTROL, {k == 3 ? 8'h02 : 8'h01});
            repeat (30) @(negedge ref_clk);
            chk("busy cycles", (k == 0 || k == 3) ? PC : 0, busy_cyc - p);
            chk("erase select", k == 3, erase_sel);
            rd(osc_regs_pkg::OFS_NV_CONTROL, 1, q);
            chk("control go bits", 0, q[0] & 8'h03);
        end
        $display("unlock test done");
        complete_run();
    end
endmodule
